/* logic/sdc_pkg.sv */
package sdc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FAULT          = 5'h00;
  localparam logic [4:0] ADDR_DIAG1          = 5'h01;
  localparam logic [4:0] ADDR_DIAG2          = 5'h02;
  localparam logic [4:0] ADDR_TORQUE_SLEW    = 5'h03;
  localparam logic [4:0] ADDR_OUTPUT_DECAY   = 5'h04;
  localparam logic [4:0] ADDR_STEP_MICRO     = 5'h05;
  localparam logic [4:0] ADDR_FAULT_LOCK     = 5'h06;
  localparam logic [4:0] ADDR_STALL_OPENLOAD = 5'h07;
  localparam logic [4:0] ADDR_STALL_THRESH   = 5'h08;
  localparam logic [4:0] ADDR_TORQUE_COUNT   = 5'h09;
  localparam logic [4:0] ADDR_REVISION       = 5'h0A;

  localparam int unsigned CTRL_NUM           = 7;
  localparam int unsigned IDX_OUTPUT_DECAY   = 1;
  localparam int unsigned IDX_FAULT_LOCK     = 3;
  localparam int unsigned IDX_STALL_OPENLOAD = 4;

  // writable bits per control register, reserved bits stay zero
  localparam logic [7:0] CTRL_WMASK [CTRL_NUM] =
    '{8'hF3, 8'h9F, 8'hFF, 8'h7F, 8'h38, 8'hFF, 8'hFF};
  localparam logic [7:0] EXT_WMASK           = 8'h07;
  localparam logic [7:0] DIAG2_MASK          = 8'hFB;
  localparam logic [7:0] FAULT_RST           = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_OUTPUT_DISABLE = 7;
  localparam int unsigned BIT_CLEAR_FAULT    = 7;
  localparam int unsigned OPEN_LOAD_TIME_FIELD_MSB        = 2;
  localparam int unsigned OPEN_LOAD_TIME_FIELD_LSB        = 1;
  localparam int unsigned BIT_DECAY_BLANK    = 0;
  localparam int unsigned HDR_CLEAR_BIT      = 5;
  localparam int unsigned CMD_RW_BIT         = 6;
  localparam int unsigned CMD_ADDR_MSB       = 5;
  localparam int unsigned CMD_ADDR_LSB       = 1;

  // ----------------------------------------------------------------
  // frame coding
  // ----------------------------------------------------------------
  localparam logic [1:0] STATUS_TAG          = 2'h3;
  localparam logic [1:0] HEADER_TAG          = 2'h2;
  localparam logic [5:0] MAX_DEVICES         = 6'h3F;
  localparam logic [7:0] HEADER_BYTES        = 8'h02;
  localparam logic [7:0] COUNT_FULL          = 8'hFF;

  typedef enum logic [2:0] {
    SDC_IDLE  = 3'h0,
    SDC_COUNT = 3'h1,
    SDC_SECOND_HEADER_BYTE  = 3'h3,
    SDC_BODY  = 3'h2,
    SDC_BAD   = 3'h6
  } sdc_state_e;

endpackage

/* logic/sdc_byte_if.sv */
`timescale 1ns/100ps

interface sdc_byte_if;
  logic       frame_active;
  logic       frame_end;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [7:0] byte_cnt;
  logic       bit_partial;
  logic [7:0] tx_byte;

  modport engine (
    output frame_active, frame_end, byte_done, rx_byte, byte_cnt, bit_partial,
    input  tx_byte
  );
  modport framer (
    input  frame_active, frame_end, byte_done, rx_byte, byte_cnt, bit_partial,
    output tx_byte
  );
endinterface

/* logic/sdc_serial_engine.sv */
`timescale 1ns/100ps

module sdc_serial_engine
  import sdc_pkg::*;
(
  input  wire logic   clock_i,
  input  wire logic   sys_rst_i,
  input  wire logic   chip_select_low_i,
  input  wire logic   serial_clock_i,
  input  wire logic   serial_data_i,
  output logic        serial_data_o,
  output logic        serial_data_oe_o,
  sdc_byte_if.engine  bus
);

  logic [1:0] cs_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic       sclk_prev_reg;
  logic       active_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic       sclk_fall;
  logic       sclk_rise;

  // ----------------------------------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cs_sync_reg     <= 2'h3;
      sclk_sync_reg   <= 2'h0;
      sdi_sync_reg    <= 2'h0;
      sclk_prev_reg   <= 1'b0;
      active_prev_reg <= 1'b0;
    end else begin
      cs_sync_reg     <= {cs_sync_reg[0], chip_select_low_i};
      sclk_sync_reg   <= {sclk_sync_reg[0], serial_clock_i};
      sdi_sync_reg    <= {sdi_sync_reg[0], serial_data_i};
      sclk_prev_reg   <= sclk_sync_reg[1];
      active_prev_reg <= bus.frame_active;
    end
  end

  assign bus.frame_active = ~cs_sync_reg[1];
  assign bus.frame_end    = active_prev_reg & ~bus.frame_active;
  assign sclk_fall        = bus.frame_active & sclk_prev_reg & ~sclk_sync_reg[1];
  assign sclk_rise        = bus.frame_active & ~sclk_prev_reg & sclk_sync_reg[1];
  assign bus.bit_partial  = bit_cnt_reg != 3'h0;
  assign serial_data_oe_o = bus.frame_active;

  // ----------------------------------------------------------------
  // receive: sample on falling edge, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !bus.frame_active) begin
      bit_cnt_reg  <= 3'h0;
      bus.byte_cnt <= 8'h00;
      bus.byte_done <= 1'b0;
    end else begin
      bus.byte_done <= sclk_fall && bit_cnt_reg == 3'h7;
      if (sclk_fall) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7 && bus.byte_cnt != COUNT_FULL) begin
          bus.byte_cnt <= bus.byte_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_shift_reg <= 8'h00;
      bus.rx_byte  <= 8'h00;
    end else if (sclk_fall) begin
      rx_shift_reg <= {rx_shift_reg[6:0], sdi_sync_reg[1]};
      if (bit_cnt_reg == 3'h7) begin
        bus.rx_byte <= {rx_shift_reg[6:0], sdi_sync_reg[1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit: drive on rising edge, slot byte loaded at bit 0
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !bus.frame_active) begin
      serial_data_o <= 1'b0;
      tx_shift_reg  <= 8'h00;
    end else if (sclk_rise) begin
      if (bit_cnt_reg == 3'h0) begin
        serial_data_o <= bus.tx_byte[7];
        tx_shift_reg  <= {bus.tx_byte[6:0], 1'b0};
      end else begin
        serial_data_o <= tx_shift_reg[7];
        tx_shift_reg  <= {tx_shift_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_byte_on_fall: assert property (
    bus.byte_done |-> $past(sclk_fall) && $past(bit_cnt_reg) == 3'h7)
    else $error("byte completed without eighth falling edge");

  chk_idle_counts: assert property (
    !bus.frame_active |=> bit_cnt_reg == 3'h0 && bus.byte_cnt == 8'h00)
    else $error("counters not cleared while chip select high");

  chk_msb_drive: assert property (
    sclk_rise && bit_cnt_reg == 3'h0 |=> serial_data_o == $past(bus.tx_byte[7]))
    else $error("slot msb not driven first");

endmodule // sdc_serial_engine

/* logic/sdc_register_port.sv */
`timescale 1ns/100ps

// Function
// - chain returns N statuses, both headers, then N report bytes.
// - header clear-fault command clears fault registers at chip-select rise.
// - six-bit header field gives chain length, at most 63 devices.
// - low five bits of second header are ignored by devices.
// - each device emits its own status byte from fault register.
// - emitted status byte has both top bits set to one.
// - position from status bytes before first header; length from header.
// - own address and data captured, all other bytes passed unchanged.
// - command encoding as single device; report is addressed register content.
// - status registers 0x00 to 0x02 are read only.
// - fault register bits: summary, protocol, supplies, current, stall, thermal, load.
// - extended variant adds open-load time and blanking enable at 0x07.
// - variants differ in reset value of output disable bit.
// - sample on falling edge, drive on rising edge, msb first.
// - bit 14 read/write, bits 13..9 address, bits 7..0 data.
module sdc_register_port
  import sdc_pkg::*;
#(
  parameter logic                  EXTENDED_OPTIONS = 1'b0,
  parameter logic                  OUT_DIS_RST_BASE = 1'b0,
  parameter logic                  OUT_DIS_RST_EXT  = 1'b1,
  parameter logic [3:0]            REVISION_ID      = 4'h1, // arbitrary value
  parameter logic [CTRL_NUM*8-1:0] CTRL_RST         = 56'h0
) (
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  chip_select_low_i,
  input  wire logic                  serial_clock_i,
  input  wire logic                  serial_data_i,
  output logic                       serial_data_o,
  output logic                       serial_data_oe_o,
  input  wire logic                  supply_undervoltage_flag_i,
  input  wire logic                  pump_undervoltage_flag_i,
  input  wire logic                  overcurrent_flag_i,
  input  wire logic                  stall_flag_i,
  input  wire logic                  thermal_flag_i,
  input  wire logic                  open_load_flag_i,
  input  wire logic [7:0]            overcurrent_detail_i,
  input  wire logic [7:0]            thermal_detail_i,
  output logic                       fault_low_o,
  output logic                       output_disable_bit_o,
  output logic [1:0]                 open_load_time_field_o,
  output logic                       decay_blanking_enable_o,
  output logic [CTRL_NUM*8-1:0]      control_regs_o,
  output logic [5:0]                 chain_position_o,
  output logic [5:0]                 chain_length_field_o,
  output logic                       clear_faults_o
);

  localparam logic OUT_DIS_RST = EXTENDED_OPTIONS ? OUT_DIS_RST_EXT : OUT_DIS_RST_BASE;

  sdc_byte_if bus ();

  sdc_state_e  state_reg;
  logic [5:0]  status_cnt_reg;
  logic [5:0]  chain_len_reg;
  logic        clear_req_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  data_reg;
  logic [6:0]  fault_reg;
  logic [7:0]  diag1_reg;
  logic [7:0]  diag2_reg;
  logic [7:0]  ctrl_reg [CTRL_NUM];
  logic        clear_pulse_reg;
  logic        status_tag;
  logic        header_tag;
  logic [7:0]  own_addr_cnt;
  logic [7:0]  frame_len;
  logic        frame_ok;
  logic        commit;
  logic [4:0]  cmd_addr;
  logic        cmd_read;
  logic        in_ctrl;
  logic [4:0]  ctrl_off;
  logic        write_en;
  logic        clear_now;
  logic [6:0]  fault_set;
  logic [7:0]  fault_view;
  logic [7:0]  report;

  sdc_serial_engine u_engine (
    .clock_i           (clock_i),
    .sys_rst_i         (sys_rst_i),
    .chip_select_low_i (chip_select_low_i),
    .serial_clock_i    (serial_clock_i),
    .serial_data_i     (serial_data_i),
    .serial_data_o     (serial_data_o),
    .serial_data_oe_o  (serial_data_oe_o),
    .bus               (bus.engine)
  );

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  assign status_tag   = bus.rx_byte[7:6] == STATUS_TAG;
  assign header_tag   = bus.rx_byte[7:6] == HEADER_TAG;
  // own address sits after the headers and N-1 foreign status or address bytes, own data is last
  assign own_addr_cnt = {2'h0, chain_len_reg} + HEADER_BYTES;
  assign frame_len    = {1'b0, chain_len_reg, 1'b0} + HEADER_BYTES;
  assign frame_ok     = state_reg == SDC_BODY && !bus.bit_partial &&
                        bus.byte_cnt == frame_len && status_cnt_reg < chain_len_reg;
  assign commit       = bus.frame_end && frame_ok;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !bus.frame_active) begin
      state_reg <= SDC_IDLE;
    end else begin
      case (state_reg)
        SDC_IDLE: begin
          state_reg <= SDC_COUNT;
        end
        SDC_COUNT: begin
          if (bus.byte_done) begin
            if (status_tag && status_cnt_reg != MAX_DEVICES) begin
              state_reg <= SDC_COUNT;
            end else if (header_tag && bus.rx_byte[5:0] != 6'h00) begin
              state_reg <= SDC_SECOND_HEADER_BYTE;
            end else begin
              state_reg <= SDC_BAD;
            end
          end
        end
        SDC_SECOND_HEADER_BYTE: begin
          if (bus.byte_done) begin
            state_reg <= header_tag ? SDC_BODY : SDC_BAD;
          end
        end
        SDC_BODY: begin
          state_reg <= SDC_BODY;
        end
        SDC_BAD: begin
          state_reg <= SDC_BAD;
        end
        default: begin
          state_reg <= SDC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !bus.frame_active) begin
      status_cnt_reg <= 6'h00;
    end else if (state_reg == SDC_COUNT && bus.byte_done && status_tag &&
                 status_cnt_reg != MAX_DEVICES) begin
      status_cnt_reg <= status_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      chain_len_reg <= 6'h00;
    end else if (state_reg == SDC_COUNT && bus.byte_done && header_tag) begin
      chain_len_reg <= bus.rx_byte[5:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state_reg == SDC_IDLE) begin
      clear_req_reg <= 1'b0;
    end else if (state_reg == SDC_SECOND_HEADER_BYTE && bus.byte_done && header_tag) begin
      clear_req_reg <= bus.rx_byte[HDR_CLEAR_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cmd_reg  <= 8'h00;
      data_reg <= 8'h00;
    end else if (state_reg == SDC_BODY && bus.byte_done) begin
      if (bus.byte_cnt == own_addr_cnt) begin
        cmd_reg <= bus.rx_byte;
      end
      if (bus.byte_cnt == frame_len) begin
        data_reg <= bus.rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode and register access
  // ----------------------------------------------------------------
  assign cmd_addr  = cmd_reg[CMD_ADDR_MSB:CMD_ADDR_LSB];
  assign cmd_read  = cmd_reg[CMD_RW_BIT];
  assign in_ctrl   = cmd_addr >= ADDR_TORQUE_SLEW && cmd_addr <= ADDR_TORQUE_COUNT;
  assign ctrl_off  = cmd_addr - ADDR_TORQUE_SLEW;
  assign write_en  = commit && !cmd_read && in_ctrl;
  assign clear_now = commit && (clear_req_reg ||
                     (write_en && cmd_addr == ADDR_FAULT_LOCK &&
                      data_reg[BIT_CLEAR_FAULT]));

  for (genvar i = 0; i < CTRL_NUM; i++) begin : g_ctrl
    localparam logic [7:0] BASE = CTRL_RST[i*8 +: 8];
    localparam logic [7:0] MASK = CTRL_WMASK[i] |
      ((i == IDX_STALL_OPENLOAD && EXTENDED_OPTIONS) ? EXT_WMASK : 8'h00);
    localparam logic [7:0] RST  = (i == IDX_OUTPUT_DECAY) ?
      {OUT_DIS_RST, BASE[6:0]} : BASE;

    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        ctrl_reg[i] <= RST & MASK;
      end else if (write_en && cmd_addr == 5'(ADDR_TORQUE_SLEW + i)) begin
        ctrl_reg[i] <= data_reg & MASK;
      end
    end

    assign control_regs_o[i*8 +: 8] = ctrl_reg[i];
  end

  // ----------------------------------------------------------------
  // fault latches, set wins over clear
  // ----------------------------------------------------------------
  assign fault_set = {bus.frame_end && !frame_ok, supply_undervoltage_flag_i,
                      pump_undervoltage_flag_i, overcurrent_flag_i, stall_flag_i,
                      thermal_flag_i, open_load_flag_i};

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fault_reg <= FAULT_RST[6:0];
      diag1_reg <= FAULT_RST;
      diag2_reg <= FAULT_RST;
    end else begin
      fault_reg <= (clear_now ? 7'h00 : fault_reg) | fault_set;
      diag1_reg <= (clear_now ? 8'h00 : diag1_reg) | overcurrent_detail_i;
      diag2_reg <= (clear_now ? 8'h00 : diag2_reg) | (thermal_detail_i & DIAG2_MASK);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      clear_pulse_reg <= 1'b0;
    end else begin
      clear_pulse_reg <= clear_now;
    end
  end

  assign fault_view = {|fault_reg, fault_reg};

  always_comb begin
    report = 8'h00;
    case (cmd_addr)
      ADDR_FAULT: report = fault_view;
      ADDR_DIAG1: report = diag1_reg;
      ADDR_DIAG2: report = diag2_reg;
      ADDR_REVISION: report = {4'h0, REVISION_ID};
      default: begin
        if (in_ctrl) begin
          report = ctrl_reg[ctrl_off[2:0]];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // outgoing slot: status, report, or the previous byte
  // ----------------------------------------------------------------
  always_comb begin
    bus.tx_byte = bus.rx_byte;
    if (bus.byte_cnt == 8'h00) begin
      bus.tx_byte = {STATUS_TAG, fault_reg[5:0]};
    end else if (state_reg == SDC_BODY && bus.byte_cnt == own_addr_cnt) begin
      bus.tx_byte = report;
    end
  end

  assign fault_low_o             = ~|fault_reg;
  assign output_disable_bit_o    = ctrl_reg[IDX_OUTPUT_DECAY][BIT_OUTPUT_DISABLE];
  assign open_load_time_field_o  = ctrl_reg[IDX_STALL_OPENLOAD][OPEN_LOAD_TIME_FIELD_MSB:OPEN_LOAD_TIME_FIELD_LSB];
  assign decay_blanking_enable_o = ctrl_reg[IDX_STALL_OPENLOAD][BIT_DECAY_BLANK];
  assign chain_position_o        = status_cnt_reg + 6'h01;
  assign chain_length_field_o    = chain_len_reg;
  assign clear_faults_o          = clear_pulse_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_header_one;
    state_reg == SDC_COUNT && bus.byte_done && header_tag && bus.rx_byte[5:0] != 6'h00;
  endsequence

  sequence s_commit_clear;
    commit && clear_req_reg && fault_set == 7'h00 &&
      overcurrent_detail_i == 8'h00 && thermal_detail_i == 8'h00;
  endsequence

  chk_status_slot: assert property (
    bus.frame_active && bus.byte_cnt == 8'h00 |->
      bus.tx_byte[7:6] == 2'h3 && bus.tx_byte[5:0] == fault_view[5:0])
    else $error("status slot wrong");

  chk_chain_length: assert property (
    s_header_one |=> chain_len_reg == $past(bus.rx_byte[5:0]) ##1 state_reg != SDC_COUNT)
    else $error("chain length not taken from header");

  chk_position_count: assert property (
    state_reg == SDC_COUNT && bus.byte_done && status_tag && status_cnt_reg < 6'h3F
      |=> status_cnt_reg == $past(status_cnt_reg) + 6'h01)
    else $error("status byte not counted");

  chk_clear_fault: assert property (
    s_commit_clear |=> fault_reg == 7'h00 && diag1_reg == 8'h00 && clear_faults_o)
    else $error("clear command did not clear faults");

  chk_pass_through: assert property (
    state_reg == SDC_BODY && bus.byte_cnt != 8'h00 && bus.byte_cnt != own_addr_cnt
      |-> bus.tx_byte == bus.rx_byte)
    else $error("foreign byte altered");

  chk_report_slot: assert property (
    state_reg == SDC_BODY && bus.byte_done && bus.byte_cnt == own_addr_cnt
      |=> cmd_reg == $past(bus.rx_byte) && bus.tx_byte == report)
    else $error("report not placed in own slot");

  chk_write_commit: assert property (
    commit && !cmd_read && cmd_addr == ADDR_TORQUE_COUNT
      |=> ctrl_reg[6] == $past(data_reg))
    else $error("write not committed at frame end");

  chk_status_ro: assert property (
    commit && cmd_addr <= ADDR_DIAG2 && fault_set == 7'h00 && !clear_now
      |=> fault_reg == $past(fault_reg))
    else $error("status register changed by access");

  chk_idle_reset: assert property (
    !bus.frame_active |=> state_reg == SDC_IDLE && status_cnt_reg == 6'h00)
    else $error("frame tracking not reset");

  chk_variant_reset: assert property (
    $fell(sys_rst_i) |-> output_disable_bit_o == OUT_DIS_RST)
    else $error("output disable reset value wrong");

endmodule // sdc_register_port

/* testbench/sdc_host_model.sv */
`timescale 1ns/100ps

module sdc_host_model (
  output logic      sclk_o,
  output logic      cs_low_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];
  logic [7:0] sh;

  initial begin
    sclk_o = 1'b0;
    cs_low_o = 1'b1;
    mosi_o = 1'b0;
  end

  // sclk idles low across select edges; data changes on rise, sampled on fall
  task automatic run_frame(input int nbits);
    rx_q = {};
    cs_low_o = 1'b0;
    // odd offset keeps every pin edge off the system clock edge
    #200.2;
    for (int i = 0; i < nbits; i++) begin
      sclk_o = 1'b1;
      mosi_o = tx_q[i / 8][7 - i % 8];
      #62.5;
      sclk_o = 1'b0;
      sh = {sh[6:0], miso_i};
      if (i % 8 == 7) rx_q.push_back(sh);
      #62.5;
    end
    cs_low_o = 1'b1;
    mosi_o = ~mosi_o;
    #600;
  endtask
endmodule // sdc_host_model

/* testbench/testbench.sv */
`timescale 1ns/100ps

module testbench;
  import sdc_pkg::*;

  logic        clk, sclk, cs_low, mosi, sdo, oe, miso, fault_low, od, blank, clr;
  logic        rst = 1'b1;
  logic        seen = 1'b0;
  logic [1:0]  olt;
  logic [5:0]  pos, len;
  logic [5:0]  flg = 6'h00;
  logic [5:0]  sx = 6'h00;
  logic [5:0]  pos_q;
  logic [15:0] det = 16'h0000;
  logic [15:0] dx;
  logic [7:0]  mir [11];
  logic [7:0]  e [6];
  logic [7:0]  d, h2, s1, a1, d2;
  logic [55:0] ctrl;
  int          fails = 0;
  int          num_checks = 0;

  assign miso = oe ? sdo : 1'bz;

  sdc_host_model host (.sclk_o(sclk), .cs_low_o(cs_low), .mosi_o(mosi), .miso_i(miso));

  // revision value is arbitrary
  sdc_register_port #(.EXTENDED_OPTIONS(1'b1), .REVISION_ID(4'h3)) dut (
    .clock_i(clk), .sys_rst_i(rst), .chip_select_low_i(cs_low), .serial_clock_i(sclk),
    .serial_data_i(mosi), .serial_data_o(sdo), .serial_data_oe_o(oe),
    .supply_undervoltage_flag_i(flg[5]), .pump_undervoltage_flag_i(flg[4]),
    .overcurrent_flag_i(flg[3]), .stall_flag_i(flg[2]), .thermal_flag_i(flg[1]),
    .open_load_flag_i(flg[0]), .overcurrent_detail_i(det[15:8]), .thermal_detail_i(det[7:0]),
    .fault_low_o(fault_low), .output_disable_bit_o(od), .open_load_time_field_o(olt),
    .decay_blanking_enable_o(blank), .control_regs_o(ctrl), .chain_position_o(pos),
    .chain_length_field_o(len), .clear_faults_o(clr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) if (clr === 1'b1) seen = 1'b1;

  // position is only held while the frame is open
  always @(posedge cs_low) pos_q = pos;

  function automatic logic [7:0] cmd(input logic rd, input logic [4:0] a);
    return {1'b0, rd, a, 1'b0};
  endfunction

  function automatic logic [7:0] wm(input int a);
    if (a < 3 || a > 9) return 8'h00;
    return CTRL_WMASK[a - 3] | ((a == 7) ? EXT_WMASK : 8'h00);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input int nbits);
    @(posedge clk);
    #1;
    host.run_frame(nbits);
  endtask

  // single-device frame: header pair, command, data
  task automatic frame1(input logic [7:0] c, dv, er, input logic cl);
    h2 = {HEADER_TAG, cl, 5'($urandom)};
    host.tx_q = {8'h81, h2, c, dv};
    send(32);
    chk8(host.rx_q[0], {STATUS_TAG, sx});
    chk8(host.rx_q[1], 8'h81);
    chk8(host.rx_q[2], h2);
    chk8(host.rx_q[3], er);
    chk8({2'h0, pos}, 8'h01);
    chk8({2'h0, len}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    d = 8'($urandom(15705));
    foreach (mir[i]) mir[i] = 8'h00;
    mir[4] = 8'h80;
    mir[10] = 8'h03;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    chk8({7'h0, od}, 8'h01);
    for (int a = 0; a < 11; a++) begin
      d = 8'($urandom);
      frame1(cmd(1'b0, 5'(a)), d, mir[a], 1'b0);
      mir[a] = mir[a] & ~wm(a) | d & wm(a);
      frame1(cmd(1'b1, 5'(a)), ~d, mir[a], 1'b0);
      if (wm(a) != 8'h00) chk8(ctrl[(a - 3) * 8 +: 8], mir[a]);
    end
    chk8({5'h00, olt, blank}, {5'h00, mir[7][2:0]});
    chk8({7'h0, od}, {7'h0, mir[4][7]});
    sx = 6'($urandom) | 6'h01;
    dx = 16'($urandom);
    @(posedge clk);
    #1 flg = sx;
    det = dx;
    @(posedge clk);
    #1 flg = 6'h00;
    det = 16'h0000;
    repeat (2) @(posedge clk);
    chk8({7'h0, fault_low}, 8'h00);
    frame1(cmd(1'b1, 5'h00), 8'h00, {2'b10, sx}, 1'b0);
    frame1(cmd(1'b1, 5'h02), 8'h00, dx[7:0] & DIAG2_MASK, 1'b0);
    seen = 1'b0;
    frame1(cmd(1'b1, 5'h01), 8'h00, dx[15:8], 1'b1);
    sx = 6'h00;
    chk8({7'h0, seen}, 8'h01);
    frame1(cmd(1'b1, 5'h00), 8'h00, 8'h00, 1'b0);
    chk8({7'h0, fault_low}, 8'h01);
    frame1(cmd(1'b1, 5'h02), 8'h00, 8'h00, 1'b0);
    s1 = 8'hC0 | 8'($urandom) & 8'h3F;
    h2 = {HEADER_TAG, 1'b0, 5'($urandom)};
    a1 = 8'($urandom);
    d2 = 8'($urandom);
    host.tx_q = {s1, 8'h82, h2, cmd(1'b1, 5'h09), a1, d2};
    send(48);
    e = '{{STATUS_TAG, sx}, s1, 8'h82, h2, mir[9], a1};
    for (int i = 0; i < 6; i++) chk8(host.rx_q[i], e[i]);
    chk8({2'h0, pos_q}, 8'h02);
    chk8({2'h0, pos}, 8'h01);
    chk8({2'h0, len}, 8'h02);
    host.tx_q = {8'h81, 8'h80, cmd(1'b0, 5'h09), ~mir[9]};
    send(30);
    frame1(cmd(1'b1, 5'h09), 8'h00, mir[9], 1'b0);
    frame1(cmd(1'b1, 5'h00), 8'h00, 8'hC0, 1'b1);
    frame1(cmd(1'b1, 5'h00), 8'h00, 8'h00, 1'b0);
    tally_and_finish();
  end

  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule // testbench
